// ===== core/converter_ctrl_status_ctrl.sv
// control, sequencer and result registers of the 10-bit converter
`timescale 1ns/1ps
module converter_ctrl_status_ctrl
	import converter_ctrl_status_pkg::*;
#(
	parameter int RES_BITS = CONVERTER_CTRL_STATUS_RES_BITS
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic standby,
	input wire converter_ctrl_status_bus_type bus,
	input wire logic xfer_ack,
	input wire logic cmp_above,
	output logic [7:0] rdata,
	output logic [2:0] mux_sel,
	output logic [RES_BITS-1:0] dac_code,
	output logic sample_hold,
	output logic conv_done_irq
);
	converter_ctrl_status_ctrl_type ctrl_r;
	converter_ctrl_status_state_type state_r;
	logic [15:0] result_r [4];
	logic [7:0] temp_r;
	logic [7:0] rdata_r;
	logic [8:0] cnt_r;
	logic [3:0] step_r;
	logic [RES_BITS-1:0] sar_r;
	logic [1:0] scan_idx_r;
	logic irq_r;
	logic [2:0] mux_sel_r;
	logic [RES_BITS-1:0] dac_code_r;
	logic sample_hold_r;

	// per-step time base: total states spread over sample plus ten decisions
	function automatic logic [8:0] step_len(input logic fast);
		step_len = fast ? CONVERTER_CTRL_STATUS_STATES_FAST / 9'd11 : CONVERTER_CTRL_STATUS_STATES_SLOW / 9'd11;
	endfunction

	function automatic logic [15:0] pack_result(input logic [RES_BITS-1:0] r);
		pack_result = {r[9:2], r[1:0], 6'h00};
	endfunction

	wire clr = rst | standby;
	wire [15:0] a = bus.addr;
	wire sel_ctrl = a == CONVERTER_CTRL_STATUS_CTRL_STATUS;
	wire sel_res = a[15:3] == CONVERTER_CTRL_STATUS_RESULT_A_UPPER[15:3];
	wire [1:0] res_idx = a[2:1];
	wire res_lower = a[0];
	wire wr_ctrl = bus.wr & sel_ctrl;
	wire rd_upper = bus.rd & sel_res & ~res_lower;
	wire [1:0] group_base = 2'b00;
	// channel in scan: group bit plus index; in single: selected channel
	wire [2:0] chan = ctrl_r.scan ? {ctrl_r.sel[2], scan_idx_r} : ctrl_r.sel;
	wire [1:0] reg_idx = chan[1:0];
	wire last_in_scan = scan_idx_r == ctrl_r.sel[1:0];
	wire [8:0] slen = step_len(ctrl_r.speed);
	wire tick = cnt_r == slen - 9'd1;
	wire [RES_BITS-1:0] trial = sar_r | (10'h200 >> step_r);
	wire [RES_BITS-1:0] decided = cmp_above ? trial : sar_r;
	wire finishing = state_r == CONVERTER_CTRL_STATUS_STEP && tick && step_r == 4'd9;
	wire cycle_end = finishing && (!ctrl_r.scan || last_in_scan);
	// write of zero clears the end flag, hardware set wins
	wire end_clr = (wr_ctrl & ~bus.wdata[CONVERTER_CTRL_STATUS_BIT_END]) | xfer_ack;
	wire end_nxt = cycle_end | (ctrl_r.end_flag & ~end_clr);
	wire run_nxt = (cycle_end & ~ctrl_r.scan) ? 1'b0 :
		wr_ctrl ? bus.wdata[CONVERTER_CTRL_STATUS_BIT_RUN] : ctrl_r.run;

	wire [7:0] ctrl_rd = {ctrl_r.end_flag, ctrl_r.irq_en, ctrl_r.run, ctrl_r.scan,
		ctrl_r.speed, ctrl_r.sel};
	wire [15:0] cur_res = result_r[res_idx];
	wire [7:0] rd_nxt = sel_ctrl ? ctrl_rd :
		!sel_res ? 8'h00 :
		res_lower ? temp_r : cur_res[15:8];

	always_ff @(posedge clock) begin
		if (clr) begin
			ctrl_r <= converter_ctrl_status_ctrl_type'(CONVERTER_CTRL_STATUS_CTRL_RESET);
		end else begin
			ctrl_r.end_flag <= end_nxt;
			ctrl_r.run <= run_nxt;
			if (wr_ctrl) begin
				ctrl_r.irq_en <= bus.wdata[CONVERTER_CTRL_STATUS_BIT_IRQ_EN];
				ctrl_r.scan <= bus.wdata[CONVERTER_CTRL_STATUS_BIT_SCAN];
				ctrl_r.speed <= bus.wdata[CONVERTER_CTRL_STATUS_BIT_SPEED];
				ctrl_r.sel <= bus.wdata[2:0];
			end
		end
	end

	always_ff @(posedge clock) begin
		if (clr) begin
			temp_r <= 8'h00;
			rdata_r <= 8'h00;
		end else begin
			rdata_r <= bus.rd ? rd_nxt : 8'h00;
			if (rd_upper) begin
				temp_r <= cur_res[7:0];
			end
		end
	end

	// result registers are never bus-written
	always_ff @(posedge clock) begin
		if (clr) begin
			for (int i = 0; i < 4; i++) begin
				result_r[i] <= CONVERTER_CTRL_STATUS_RESULT_RESET;
			end
		end else if (finishing) begin
			result_r[reg_idx] <= pack_result(decided);
		end
	end

	always_ff @(posedge clock) begin
		if (clr) begin
			state_r <= CONVERTER_CTRL_STATUS_IDLE;
			cnt_r <= 9'h000;
			step_r <= 4'h0;
			sar_r <= 10'h000;
			scan_idx_r <= 2'b00;
		end else begin
			cnt_r <= (state_r == CONVERTER_CTRL_STATUS_IDLE || tick) ? 9'h000 : cnt_r + 9'd1;
			case (state_r)
				CONVERTER_CTRL_STATUS_IDLE: begin
					scan_idx_r <= group_base;
					if (ctrl_r.run) begin
						state_r <= CONVERTER_CTRL_STATUS_SAMPLE;
					end
				end
				CONVERTER_CTRL_STATUS_SAMPLE: begin
					sar_r <= 10'h000;
					step_r <= 4'h0;
					if (!ctrl_r.run) begin
						state_r <= CONVERTER_CTRL_STATUS_IDLE;
					end else if (tick) begin
						state_r <= CONVERTER_CTRL_STATUS_STEP;
					end
				end
				CONVERTER_CTRL_STATUS_STEP: begin
					if (!ctrl_r.run) begin
						state_r <= CONVERTER_CTRL_STATUS_IDLE;
					end else if (tick) begin
						sar_r <= decided;
						step_r <= step_r + 4'd1;
						if (step_r == 4'd9) begin
							state_r <= CONVERTER_CTRL_STATUS_DONE;
						end
					end
				end
				CONVERTER_CTRL_STATUS_DONE: begin
					scan_idx_r <= last_in_scan ? 2'b00 : scan_idx_r + 2'd1;
					state_r <= (ctrl_r.run && ctrl_r.scan) ? CONVERTER_CTRL_STATUS_SAMPLE : CONVERTER_CTRL_STATUS_IDLE;
				end
				default: begin
					state_r <= CONVERTER_CTRL_STATUS_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (clr) begin
			irq_r <= 1'b0;
			mux_sel_r <= 3'h0;
			dac_code_r <= '0;
			sample_hold_r <= 1'b0;
		end else begin
			irq_r <= end_nxt & ctrl_r.irq_en;
			// one cycle of lag is harmless: trial and channel hold for a whole step
			mux_sel_r <= chan;
			dac_code_r <= trial;
			sample_hold_r <= state_r == CONVERTER_CTRL_STATUS_SAMPLE;
		end
	end

	assign rdata = rdata_r;
	assign conv_done_irq = irq_r;
	assign mux_sel = mux_sel_r;
	assign dac_code = dac_code_r;
	assign sample_hold = sample_hold_r;
endmodule

// ===== inc/converter_ctrl_status_pkg.sv
// constants and types for the converter control block
package converter_ctrl_status_pkg;
	localparam logic [15:0] CONVERTER_CTRL_STATUS_RESULT_A_UPPER = 16'hFFE0;
	localparam logic [15:0] CONVERTER_CTRL_STATUS_RESULT_A_LOWER = 16'hFFE1;
	localparam logic [15:0] CONVERTER_CTRL_STATUS_RESULT_B_UPPER = 16'hFFE2;
	localparam logic [15:0] CONVERTER_CTRL_STATUS_RESULT_B_LOWER = 16'hFFE3;
	localparam logic [15:0] CONVERTER_CTRL_STATUS_RESULT_C_UPPER = 16'hFFE4;
	localparam logic [15:0] CONVERTER_CTRL_STATUS_RESULT_C_LOWER = 16'hFFE5;
	localparam logic [15:0] CONVERTER_CTRL_STATUS_RESULT_D_UPPER = 16'hFFE6;
	localparam logic [15:0] CONVERTER_CTRL_STATUS_RESULT_D_LOWER = 16'hFFE7;
	localparam logic [15:0] CONVERTER_CTRL_STATUS_CTRL_STATUS = 16'hFFE8;
	localparam logic [7:0] CONVERTER_CTRL_STATUS_CTRL_RESET = 8'h00;
	localparam logic [15:0] CONVERTER_CTRL_STATUS_RESULT_RESET = 16'h0000;
	localparam int CONVERTER_CTRL_STATUS_BIT_END = 7;
	localparam int CONVERTER_CTRL_STATUS_BIT_IRQ_EN = 6;
	localparam int CONVERTER_CTRL_STATUS_BIT_RUN = 5;
	localparam int CONVERTER_CTRL_STATUS_BIT_SCAN = 4;
	localparam int CONVERTER_CTRL_STATUS_BIT_SPEED = 3;
	localparam int CONVERTER_CTRL_STATUS_RES_BITS = 10;
	// conversion length in system clock states
	localparam logic [8:0] CONVERTER_CTRL_STATUS_STATES_SLOW = 9'h112;
	localparam logic [8:0] CONVERTER_CTRL_STATUS_STATES_FAST = 9'h08A;
	// fast setting at 10 MHz: 138 states of 100 ns give 13.8 us
	localparam int CONVERTER_CTRL_STATUS_FAST_TIME_NS = 13800;
	localparam int CONVERTER_CTRL_STATUS_REF_CLK_MHZ = 10;
	localparam int CONVERTER_CTRL_STATUS_FAST_CYCLES = CONVERTER_CTRL_STATUS_FAST_TIME_NS * CONVERTER_CTRL_STATUS_REF_CLK_MHZ / 1000;

	typedef enum logic [1:0] {
		CONVERTER_CTRL_STATUS_IDLE = 2'b00,
		CONVERTER_CTRL_STATUS_SAMPLE = 2'b01,
		CONVERTER_CTRL_STATUS_STEP = 2'b10,
		CONVERTER_CTRL_STATUS_DONE = 2'b11
	} converter_ctrl_status_state_type;

	typedef struct packed {
		logic rd;
		logic wr;
		logic [15:0] addr;
		logic [7:0] wdata;
	} converter_ctrl_status_bus_type;

	typedef struct packed {
		logic end_flag;
		logic irq_en;
		logic run;
		logic scan;
		logic speed;
		logic [2:0] sel;
	} converter_ctrl_status_ctrl_type;
endpackage

// ===== verif/converter_ctrl_status_analog_model.sv
// comparator model standing in for the analog front end
`timescale 1ns/1ps
module converter_ctrl_status_analog_model (
	input wire logic [2:0] mux_sel,
	input wire logic [9:0] dac_code,
	input wire logic [79:0] levels,
	output logic cmp_above
);
	assign cmp_above = levels[mux_sel*10 +: 10] >= dac_code;
endmodule

// ===== verif/converter_ctrl_status_ctrl_chk.sv
// port assertions for the converter control block
`timescale 1ns/1ps
module converter_ctrl_status_chk
	import converter_ctrl_status_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire logic standby,
	input wire converter_ctrl_status_bus_type bus,
	input wire logic xfer_ack,
	input wire logic [7:0] rdata,
	input wire logic conv_done_irq
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst || standby);
	sequence irq_off_wr;
		bus.wr && bus.addr == CONVERTER_CTRL_STATUS_CTRL_STATUS && !bus.wdata[6];
	endsequence
	chk_rd_idle: assert property (!bus.rd |=> rdata == 8'h00)
		else $error("read data without read");
	chk_low_zero: assert property (bus.rd && bus.addr[15:3] == 13'h1FFC && bus.addr[0]
		|=> rdata[5:0] == 6'h00) else $error("lower byte unused bits set");
	chk_below_map: assert property (bus.rd && bus.addr < CONVERTER_CTRL_STATUS_RESULT_A_UPPER
		|=> rdata == 8'h00) else $error("unmapped read nonzero");
	chk_above_map: assert property (bus.rd && bus.addr > CONVERTER_CTRL_STATUS_CTRL_STATUS
		|=> rdata == 8'h00) else $error("unmapped read nonzero");
	chk_irq_off: assert property (irq_off_wr |-> ##2 !conv_done_irq)
		else $error("request stays after disable");
	chk_ack_clear: assert property (xfer_ack |-> ##2 !conv_done_irq)
		else $error("request stays after transfer");
	chk_irq_hold: assert property (conv_done_irq && !xfer_ack && !$past(xfer_ack)
		&& !bus.wr && !$past(bus.wr) |=> conv_done_irq) else $error("request dropped");
	chk_rst_clear: assert property ($fell(rst) |-> rdata == 8'h00 && !conv_done_irq)
		else $error("outputs not cleared by reset");
endmodule

bind converter_ctrl_status_ctrl converter_ctrl_status_chk i_chk (.clock(clock), .rst(rst), .standby(standby), .bus(bus),
	.xfer_ack(xfer_ack), .rdata(rdata), .conv_done_irq(conv_done_irq));

// ===== verif/converter_ctrl_status_ctrl_tb.sv
// self-checking bench for the converter control block
`timescale 1ns/1ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin failures++; \
	$display("BAD %0t got %h want %h", $time, a, e); end end
module converter_ctrl_status_ctrl_tb
	import converter_ctrl_status_pkg::*;
;
	logic clock = 0, rst = 1, standby = 0, xfer_ack = 0, cmp_above;
	converter_ctrl_status_bus_type bus = '0;
	logic [7:0] rdata;
	logic [2:0] mux_sel;
	logic [9:0] dac_code;
	logic sample_hold, conv_done_irq;
	logic [79:0] levels = '0;
	int failures = 0, num_checks = 0, n;
	converter_ctrl_status_ctrl i_dut (.clock(clock), .rst(rst), .standby(standby), .bus(bus),
		.xfer_ack(xfer_ack), .cmp_above(cmp_above), .rdata(rdata), .mux_sel(mux_sel),
		.dac_code(dac_code), .sample_hold(sample_hold), .conv_done_irq(conv_done_irq));
	converter_ctrl_status_analog_model i_ana (.mux_sel(mux_sel), .dac_code(dac_code), .levels(levels),
		.cmp_above(cmp_above));
	initial forever #25 clock = ~clock;
	task give_verdict;
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task wr(input logic [15:0] a, input logic [7:0] d);
		@(negedge clock);
		bus.wr = 1; bus.addr = a; bus.wdata = d;
		@(negedge clock);
		bus.wr = 0;
	endtask
	task rd(input logic [15:0] a, input logic [7:0] e);
		@(negedge clock);
		bus.rd = 1; bus.addr = a;
		@(negedge clock);
		bus.rd = 0;
		`CHK(rdata, e)
	endtask
	task wait_irq(output int c);
		c = 0;
		while (conv_done_irq !== 1'b1 && c < 1000) begin
			@(negedge clock);
			c++;
		end
		if (c >= 1000) failures++;
	endtask
	initial begin
		repeat (3) @(negedge clock);
		rst = 0;
		for (int a = 0; a < 10; a++) rd(16'hFFE0 + a, 8'h00);
		wr(16'hFFE2, 8'hFF);
		rd(16'hFFE2, 8'h00);
		$display("test reset done");
		levels[59:50] = 10'h2B5;
		wr(CONVERTER_CTRL_STATUS_CTRL_STATUS, 8'h6D);
		wait_irq(n);
		`CHK(n inside {[120:150]}, 1'b1)
		rd(CONVERTER_CTRL_STATUS_CTRL_STATUS, 8'hCD);
		rd(16'hFFE2, 8'hAD);
		rd(16'hFFE3, 8'h40);
		rd(16'hFFE1, 8'h40);
		wr(CONVERTER_CTRL_STATUS_CTRL_STATUS, 8'h4D);
		rd(CONVERTER_CTRL_STATUS_CTRL_STATUS, 8'h4D);
		`CHK(conv_done_irq, 1'b0)
		wr(CONVERTER_CTRL_STATUS_CTRL_STATUS, 8'hCD);
		rd(CONVERTER_CTRL_STATUS_CTRL_STATUS, 8'h4D);
		$display("test single done");
		levels[9:0] = 10'h3FF;
		wr(CONVERTER_CTRL_STATUS_CTRL_STATUS, 8'h60);
		wait_irq(n);
		`CHK(n >= 264, 1'b1)
		@(negedge clock) xfer_ack = 1;
		@(negedge clock) xfer_ack = 0;
		rd(CONVERTER_CTRL_STATUS_CTRL_STATUS, 8'h40);
		rd(16'hFFE0, 8'hFF);
		rd(16'hFFE1, 8'hC0);
		$display("test transfer done");
		@(negedge clock) standby = 1;
		@(negedge clock) standby = 0;
		rd(16'hFFE0, 8'h00);
		rd(CONVERTER_CTRL_STATUS_CTRL_STATUS, 8'h00);
		$display("test standby done");
		levels[49:40] = 10'h155;
		wr(CONVERTER_CTRL_STATUS_CTRL_STATUS, 8'h7D);
		repeat (2) @(negedge clock);
		`CHK(mux_sel, 3'h4)
		`CHK(sample_hold, 1'b1)
		`CHK(dac_code, 10'h200)
		wait_irq(n);
		wr(CONVERTER_CTRL_STATUS_CTRL_STATUS, 8'h5D);
		rd(CONVERTER_CTRL_STATUS_CTRL_STATUS, 8'h5D);
		rd(16'hFFE0, 8'h55);
		rd(16'hFFE2, 8'hAD);
		$display("test scan done");
		give_verdict;
	end
	initial begin
		repeat (3000) @(posedge clock);
		failures++;
		give_verdict;
	end
endmodule
